// *** rtl/sodc_halt_gate.sv ***
// Glitch-free stop gate for one post divider clock
`timescale 1ns/1ps
module sodc_halt_gate
  import sodc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_in,
  input wire logic [1:0] stop_code,
  output logic clk_out
);
  `include "sodc_params.svh"
  sodc_halt_t state_r;
  sodc_halt_t state_nxt;
  logic out_r;
  logic in_d_r;
  wire stop_req = stop_code[1];
  wire stop_high = (stop_code == `SODC_HALT_HIGH);
  wire edge_match = stop_high ? (clk_in & ~in_d_r) : (~clk_in & in_d_r);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SODC_RUN:
        if (stop_req)
          state_nxt = SODC_WAIT;
      SODC_WAIT:
        if (!stop_req)
          state_nxt = SODC_RUN;
        else if (edge_match)
          state_nxt = SODC_HELD; // RULE7 RULE8
      SODC_HELD:
        // Leave only when the source matches the held level
        if (!stop_req && clk_in == out_r)
          state_nxt = SODC_RUN; // RULE15
        else if (stop_high != out_r && clk_in == out_r)
          state_nxt = SODC_WAIT; // RULE7 RULE8
      default:
        state_nxt = SODC_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= SODC_RUN;
      out_r <= 1'b0;
      in_d_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      in_d_r <= clk_in;
      // Edge that enters the hold still passes, so the held level is the new one
      if (state_r != SODC_HELD)
        out_r <= clk_in; // RULE15
    end
  end

  assign clk_out = out_r;
endmodule

// *** rtl/sodc_params.svh ***
// Register offsets, field codes and reset values for the output divider control
`ifndef SODC_PARAMS_SVH
`define SODC_PARAMS_SVH
`define SODC_ADDR_DIVB0 8'h89
`define SODC_ADDR_DIVB1 8'h8a
`define SODC_ADDR_DIVB2 8'h8b
`define SODC_ADDR_DRVEN 8'hb1
`define SODC_ADDR_HALT 8'hb8
`define SODC_ADDR_LOCK 8'hb9
`define SODC_ADDR_CLEAR 8'hba
`define SODC_DIVB_RST 24'h00000c
`define SODC_BYTE_RST 8'h00
`define SODC_TYPE_FRAME 4'hf
`define SODC_SRC_LOWF 2'h1
`define SODC_SRC_DIVA 2'h2
`define SODC_SRC_LFCK 2'h3
`define SODC_HALT_LOW 2'h2
`define SODC_HALT_HIGH 2'h3
`endif

// *** rtl/sodc_pkg.sv ***
// Types for the output divider control
package sodc_pkg;
  typedef enum logic [1:0] {SODC_RUN, SODC_WAIT, SODC_HELD} sodc_halt_t;
  typedef enum logic [1:0] {SODC_DIVIDE, SODC_LOWFREQ, SODC_FRAME} sodc_mode_t;
endpackage

// *** rtl/sodc_top.sv ***
// Output divider control: post divider B modes, driver enables, stop control, lock flag
// Notes on behaviour
// RULE1: Frame mode bit 18 selects pulse polarity
// RULE2: Frame mode bit 19 selects boundary alignment
// RULE3: Type 1111, source 01: low-frequency clock
// RULE4: Type 1111 otherwise: one-period frame pulse
// RULE5: Other types: divide by full 24 bits
// RULE6: Enable bits drive outputs, else tristate
// RULE7: Divider A stop codes halt low/high
// RULE8: Divider B stop codes halt low/high
// RULE9: Lock loss sets sticky status bit
// RULE10: Status bit set at reset
// RULE11: Software trusts status only after clearing
// RULE12: Clear bit one clears, software returns zero
// RULE13: Source 10 divider A, 11 low clock
// RULE14: Bits 15:0 give periods between pulses
// RULE15: Stop and resume without runt pulses
// RULE16: Reserved bits written as zero
`timescale 1ns/1ps
module sodc_top
  import sodc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  input wire logic synth_clk,
  input wire logic div_a_clk,
  input wire logic lock_lost,
  output logic fast_output_0,
  output logic fast_output_0_oe,
  output logic fast_output_1,
  output logic fast_output_1_oe
);
  `include "sodc_params.svh"
  logic [23:0] divb_r;
  logic [7:0] drven_r;
  logic [7:0] halt_r;
  logic lock_lost_sticky_r;
  logic lock_lost_clear_r;
  logic [23:0] cnt_r;
  logic [23:0] cnt_nxt;
  logic [15:0] lf_cnt_r;
  logic lf_clk_r;
  logic [15:0] fp_cnt_r;
  logic fp_act_r;
  logic divb_out_r;
  logic synth_d_r;
  logic diva_d_r;
  logic lf_d_r;
  logic [7:0] rdata_r;
  logic fast_out_clock_0;
  logic fast_out_clock_1;
  sodc_mode_t mode;

  wire wr_divb0 = reg_wr && reg_addr == `SODC_ADDR_DIVB0;
  wire wr_divb1 = reg_wr && reg_addr == `SODC_ADDR_DIVB1;
  wire wr_divb2 = reg_wr && reg_addr == `SODC_ADDR_DIVB2;
  wire wr_drven = reg_wr && reg_addr == `SODC_ADDR_DRVEN;
  wire wr_halt = reg_wr && reg_addr == `SODC_ADDR_HALT;
  wire wr_clear = reg_wr && reg_addr == `SODC_ADDR_CLEAR;
  wire [3:0] out_type = divb_r[23:20];
  wire [1:0] fp_src = divb_r[17:16];
  wire fp_neg = divb_r[18]; // RULE1
  wire fp_first_edge = divb_r[19]; // RULE2
  wire [15:0] fp_rate = divb_r[15:0];
  wire synth_rise = synth_clk & ~synth_d_r;
  wire diva_rise = div_a_clk & ~diva_d_r;
  wire lf_rise = lf_clk_r & ~lf_d_r;
  // Source code 00 is reserved in frame mode and gives no ticks; 01 selects low-frequency mode instead
  wire fp_tick = (fp_src == `SODC_SRC_DIVA) ? diva_rise :
                 (fp_src == `SODC_SRC_LFCK) ? lf_rise : 1'b0; // RULE13
  // Half-period compare keeps 50% duty for even dividers
  wire [23:0] half_div = {1'b0, divb_r[23:1]};
  wire [15:0] lf_half = fp_rate;
  wire cnt_wrap = (cnt_r >= divb_r - 24'h000001);
  wire fp_wrap = (fp_cnt_r >= fp_rate - 16'h0001); // RULE14
  // First-edge-aligned pulse (bit 19 set) starts one selected-clock period early in the frame count
  wire fp_start = fp_first_edge ? fp_wrap : (fp_cnt_r == 16'h0000 && !fp_act_r);
  wire lock_set = lock_lost; // RULE9
  wire lock_clr = lock_lost_clear_r && !lock_set; // RULE12

  assign mode = (out_type != `SODC_TYPE_FRAME) ? SODC_DIVIDE :
                (fp_src == `SODC_SRC_LOWF) ? SODC_LOWFREQ : SODC_FRAME;
  assign cnt_nxt = (cnt_wrap || divb_r == 24'h000000) ? 24'h000000 : cnt_r + 24'h000001;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divb_r <= `SODC_DIVB_RST;
      drven_r <= `SODC_BYTE_RST;
      halt_r <= `SODC_BYTE_RST;
      lock_lost_clear_r <= 1'b0;
    end
    else
    begin
      if (wr_divb0)
        divb_r[7:0] <= reg_wdata;
      if (wr_divb1)
        divb_r[15:8] <= reg_wdata;
      if (wr_divb2)
        divb_r[23:16] <= reg_wdata;
      if (wr_drven)
        drven_r <= {6'h00, reg_wdata[1:0]}; // RULE16
      if (wr_halt)
        halt_r <= {4'h0, reg_wdata[3:0]}; // RULE16
      if (wr_clear)
        lock_lost_clear_r <= reg_wdata[0]; // RULE12
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lock_lost_sticky_r <= 1'b1; // RULE10
    else if (lock_set)
      lock_lost_sticky_r <= 1'b1; // RULE9 RULE11
    else if (lock_clr)
      lock_lost_sticky_r <= 1'b0; // RULE12
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      synth_d_r <= 1'b0;
      diva_d_r <= 1'b0;
      lf_d_r <= 1'b0;
    end
    else
    begin
      synth_d_r <= synth_clk;
      diva_d_r <= div_a_clk;
      lf_d_r <= lf_clk_r;
    end
  end

  // Full 24-bit divider on synthesizer clock edges
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 24'h000000;
    else if (synth_rise)
      cnt_r <= cnt_nxt; // RULE5
  end

  // Low-frequency clock toggles every rate count, so base over twice the divider
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lf_cnt_r <= 16'h0000;
      lf_clk_r <= 1'b0;
    end
    else if (synth_rise)
    begin
      if (lf_cnt_r >= lf_half - 16'h0001 || lf_half == 16'h0000)
      begin
        lf_cnt_r <= 16'h0000;
        lf_clk_r <= ~lf_clk_r; // RULE3
      end
      else
        lf_cnt_r <= lf_cnt_r + 16'h0001;
    end
  end

  // Frame pulse counter in selected-clock periods
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fp_cnt_r <= 16'h0000;
      fp_act_r <= 1'b0;
    end
    else if (mode != SODC_FRAME)
    begin
      fp_cnt_r <= 16'h0000;
      fp_act_r <= 1'b0;
    end
    else if (fp_tick)
    begin
      fp_cnt_r <= fp_wrap ? 16'h0000 : fp_cnt_r + 16'h0001; // RULE14
      fp_act_r <= fp_start; // RULE4 RULE2
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      divb_out_r <= 1'b0;
    else
    begin
      case (mode)
        SODC_DIVIDE:
          divb_out_r <= (cnt_r < half_div); // RULE5
        SODC_LOWFREQ:
          divb_out_r <= lf_clk_r; // RULE3
        SODC_FRAME:
          divb_out_r <= fp_act_r ^ fp_neg; // RULE1 RULE4
        default:
          divb_out_r <= 1'b0;
      endcase
    end
  end

  sodc_halt_gate u_gate_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_in(div_a_clk),
    .stop_code(halt_r[1:0]),
    .clk_out(fast_out_clock_0)
  ); // RULE7

  sodc_halt_gate u_gate_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_in(divb_out_r),
    .stop_code(halt_r[3:2]),
    .clk_out(fast_out_clock_1)
  ); // RULE8

  assign fast_output_0 = fast_out_clock_0;
  assign fast_output_1 = fast_out_clock_1;
  assign fast_output_0_oe = drven_r[0]; // RULE6
  assign fast_output_1_oe = drven_r[1]; // RULE6

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 8'h00;
    else
    begin
      case (reg_addr)
        `SODC_ADDR_DIVB0: rdata_r <= divb_r[7:0];
        `SODC_ADDR_DIVB1: rdata_r <= divb_r[15:8];
        `SODC_ADDR_DIVB2: rdata_r <= divb_r[23:16];
        `SODC_ADDR_DRVEN: rdata_r <= drven_r;
        `SODC_ADDR_HALT: rdata_r <= halt_r;
        `SODC_ADDR_LOCK: rdata_r <= {7'h00, lock_lost_sticky_r};
        `SODC_ADDR_CLEAR: rdata_r <= {7'h00, lock_lost_clear_r};
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_r;
endmodule

// *** tb/sodc_far_model.sv ***
// Far side: source clocks in, receiving lines out
`timescale 1ns/1ps
module sodc_far_model
(
  output logic synth_clk,
  output logic div_a_clk,
  input wire logic out0,
  input wire logic oe0,
  input wire logic out1,
  input wire logic oe1,
  output logic line0,
  output logic line1
);
  initial
  begin
    synth_clk = 1'b0;
    #100;
    forever #200 synth_clk = ~synth_clk;
  end
  initial
  begin
    div_a_clk = 1'b0;
    #100;
    forever #400 div_a_clk = ~div_a_clk;
  end
  // Released line shows inverse of the current output value
  assign line0 = oe0 ? out0 : ~out0;
  assign line1 = oe1 ? out1 : ~out1;
endmodule

// *** tb/sodc_top_props.sv ***
// Port checker for the output divider control
`timescale 1ns/1ps
module sodc_props
  import sodc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic synth_clk,
  input wire logic div_a_clk,
  input wire logic lock_lost,
  input wire logic fast_output_0,
  input wire logic fast_output_0_oe,
  input wire logic fast_output_1,
  input wire logic fast_output_1_oe
);
  wire hw = reg_wr && reg_addr == 8'hb8;
  logic [3:0] halt_r;
  logic [7:0] hcnt_r;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      halt_r <= 4'h0;
      hcnt_r <= 8'h00;
    end
    else
    begin
      halt_r <= hw ? reg_wdata[3:0] : halt_r;
      hcnt_r <= hw ? 8'h00 : hcnt_r + {7'h00, hcnt_r != 8'hff};
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_oe0;
    reg_wr && reg_addr == 8'hb1 |=> fast_output_0_oe == $past(reg_wdata[0]);
  endproperty
  a_oe0: assert property (p_oe0) else $error("oe0 wrong");
  property p_oe1;
    reg_wr && reg_addr == 8'hb1 |=> fast_output_1_oe == $past(reg_wdata[1]);
  endproperty
  a_oe1: assert property (p_oe1) else $error("oe1 wrong");
  property p_rsvd;
    reg_addr == 8'hb1 |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_set;
    (lock_lost && reg_addr == 8'hb9) [*3] |-> reg_rdata[0];
  endproperty
  a_set: assert property (p_set) else $error("sticky not set");
  property p_rst;
    $rose(rst_n) && reg_addr == 8'hb9 |=> reg_rdata[0];
  endproperty
  a_rst: assert property (p_rst) else $error("sticky not set at reset");
  property p_clr;
    reg_wr && reg_addr == 8'hba && reg_wdata[0] ##1 (!lock_lost && reg_addr == 8'hb9) [*4]
      |-> !reg_rdata[0];
  endproperty
  a_clr: assert property (p_clr) else $error("sticky not cleared");
  property p_halt0;
    hcnt_r > 8'hc8 && halt_r[1] |-> $stable(fast_output_0);
  endproperty
  a_halt0: assert property (p_halt0) else $error("output 0 not halted");
  property p_halt1;
    hcnt_r > 8'hc8 && halt_r[3] |-> $stable(fast_output_1);
  endproperty
  a_halt1: assert property (p_halt1) else $error("output 1 not halted");
endmodule
bind sodc_top sodc_props chk_u (.*);

// *** tb/sodc_top_tb.sv ***
// Testbench for the output divider control
`timescale 1ns/1ps
module sodc_top_tb;
  import sodc_pkg::*;
  logic clk_sys, rst_n, reg_wr, lock_lost;
  logic [7:0] reg_addr, reg_wdata;
  wire [7:0] reg_rdata;
  wire synth_clk, div_a_clk, o0, e0, o1, e1, line0, line1;
  int n_errors = 0;
  int comparisons = 0;
  sodc_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .synth_clk(synth_clk), .div_a_clk(div_a_clk),
    .lock_lost(lock_lost), .fast_output_0(o0), .fast_output_0_oe(e0), .fast_output_1(o1),
    .fast_output_1_oe(e1));
  sodc_far_model far_u (.synth_clk(synth_clk), .div_a_clk(div_a_clk), .out0(o0), .oe0(e0),
    .out1(o1), .oe1(e1), .line0(line0), .line1(line1));
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= 8'hb9;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp8("rdata", e, reg_rdata);
  endtask
  // Second pass only, first one settles after a mode change
  task automatic meas(input logic [7:0] per_e, input logic [7:0] hi_e);
    logic [7:0] per, hi;
    int st;
    logic prev;
    repeat (2)
    begin
      per = 8'h00;
      hi = 8'h00;
      st = 0;
      prev = line1;
      repeat (400)
      begin
        @(negedge clk_sys);
        if (!prev && line1) st++;
        if (st == 2) break;
        per += 8'(st == 1);
        hi += 8'(st == 1 && line1);
        prev = line1;
      end
    end
    cmp8("period", per_e, per);
    cmp8("high time", hi_e, hi);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end
  initial
  begin
    rst_n = 1'b0;
    reg_addr = 8'hb9;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    lock_lost = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'hb9, 8'h01);
    rd(8'h89, 8'h0c);
    rd(8'hb1, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'hb1, 8'h03);
    rd(8'hb1, 8'h03);
    cmp8("enables", 8'h03, {6'h00, e1, e0});
    wr(8'hb9, 8'h00);
    rd(8'hb9, 8'h01);
    $display("registers done");
    wr(8'hba, 8'h01);
    rd(8'hb9, 8'h00);
    wr(8'hba, 8'h00);
    @(posedge clk_sys);
    lock_lost <= 1'b1;
    rd(8'hb9, 8'h01);
    lock_lost <= 1'b0;
    rd(8'hb9, 8'h01);
    $display("lock flag done");
    meas(8'h30, 8'h18);
    wr(8'h89, 8'h06);
    meas(8'h18, 8'h0c);
    wr(8'h89, 8'h03);
    wr(8'h8b, 8'hf1);
    meas(8'h18, 8'h0c);
    wr(8'h89, 8'h04);
    wr(8'h8b, 8'hf2);
    meas(8'h20, 8'h08);
    wr(8'h8b, 8'hf6);
    meas(8'h20, 8'h18);
    wr(8'h8b, 8'hfa);
    meas(8'h20, 8'h08);
    wr(8'h8b, 8'hf3);
    meas(8'h80, 8'h20);
    $display("modes done");
    wr(8'h8b, 8'h00);
    wr(8'h89, 8'h06);
    wr(8'hb8, 8'h0b);
    repeat (300) @(negedge clk_sys);
    cmp8("halted lines", 8'h01, {6'h00, line1, line0});
    wr(8'hb8, 8'h0e);
    repeat (300) @(negedge clk_sys);
    cmp8("halted lines", 8'h02, {6'h00, line1, line0});
    wr(8'hb8, 8'h00);
    meas(8'h18, 8'h0c);
    wr(8'hb1, 8'h00);
    @(negedge clk_sys);
    cmp8("enables", 8'h00, {6'h00, e1, e0});
    $display("halt and enable done");
    end_of_test();
  end
endmodule
